// ### verilog/sge_defs.svh
// constants of the serial gain and equalizer configuration block
`ifndef SGE_DEFS_SVH
`define SGE_DEFS_SVH
// configuration word layout
`define SGE_WORD_W 7
`define SGE_SEL_LSB 0
`define SGE_SEL_MSB 1
`define SGE_FIELD_LSB 2
`define SGE_FIELD_MSB 5
`define SGE_OPT_BIT 6
// control register reset values
`define SGE_FINE_RST 4'h0
`define SGE_COARSE_RST 2'h0
`define SGE_EQ_RST 2'h0
`define SGE_ACTIVE_RST 1'b1
// pin vector positions inside the front end
`define SGE_PIN_CS 0
`define SGE_PIN_WE 1
`define SGE_PIN_DIN 2
`define SGE_PIN_OSC 3
`define SGE_PIN_RSEL_LSB 4
`define SGE_PIN_RSEL_MSB 5
`define SGE_PIN_W 6
`define SGE_PIN_RST 6'h03
// oscillator and sampling rates, in Hz
`define SGE_FS_HZ 153600
`define SGE_OSC_HI_HZ 11059200
`define SGE_OSC_MID_HZ 3686400
`define SGE_OSC_LO_HZ 2457600
// half periods of the sampling clock, in oscillator rising edges
`define SGE_HALF_HI (`SGE_OSC_HI_HZ / `SGE_FS_HZ / 2)
`define SGE_HALF_MID (`SGE_OSC_MID_HZ / `SGE_FS_HZ / 2)
`define SGE_HALF_LO (`SGE_OSC_LO_HZ / `SGE_FS_HZ / 2)
`endif

// ### verilog/sge_pkg.sv
// types of the serial gain and equalizer configuration block
package sge_pkg;
  `include "sge_defs.svh"
  typedef logic [`SGE_WORD_W-1:0] sge_word_t;
  typedef enum logic [1:0] {
    SGE_SEL_EQ = 2'h0,
    SGE_SEL_FINE = 2'h1,
    SGE_SEL_COARSE = 2'h2,
    SGE_SEL_POWER = 2'h3
  } sge_sel_e;
  typedef enum logic [1:0] {
    SGE_RATIO_VSS = 2'h0,
    SGE_RATIO_DGND = 2'h1,
    SGE_RATIO_VDD = 2'h2
  } sge_ratio_e;
endpackage

// ### verilog/sge_cfg_if.sv
// carrier between the pin front end and the register core
`timescale 1ns/100ps
interface sge_cfg_if;
  logic [6:0] word;
  logic latch;
  logic osc_rise;
  logic osc_level;
  logic [1:0] ratio_sel;
  modport rx (output word, output latch, output osc_rise, output osc_level, output ratio_sel);
  modport core (input word, input latch, input osc_rise, input osc_level, input ratio_sel);
endinterface

// ### verilog/sge_pin_rx.sv
// pin front end: synchronisers, write strobe shifter, chip-select latch pulse
`timescale 1ns/100ps
`include "sge_defs.svh"
module sge_pin_rx
  import sge_pkg::*;
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // raw pins
  input wire logic i_cs_b,
  input wire logic i_we_b,
  input wire logic i_din,
  input wire logic i_osc_input,
  input wire logic [1:0] i_clock_ratio_select,
  // toward the core
  sge_cfg_if.rx cfg
);
  localparam int W = `SGE_PIN_W;
  // idle level of every pin, loaded by reset so no false edge follows it
  localparam logic [W-1:0] RST_V = `SGE_PIN_RST;

  logic [W-1:0] raw;
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] flt_d;
  logic [W-1:0] flt_q;
  logic [`SGE_WORD_W-1:0] shift_q;
  logic latch_q;
  logic osc_rise_q;
  wire we_rise;
  wire cs_rise;
  wire cs_low;

  assign raw = {i_clock_ratio_select, i_osc_input, i_din, i_we_b, i_cs_b};

  // -----------------------------------------------
  // three-stage synchronisers, one per pin bit
  // -----------------------------------------------
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_sync
      // a level only counts once stages two and three agree
      assign flt_d[g] = (s2_q[g] == s3_q[g]) ? s3_q[g] : flt_q[g];
      always_ff @(posedge i_sys_clk) begin
        if (!i_rst_b) begin
          s1_q[g] <= RST_V[g];
          s2_q[g] <= RST_V[g];
          s3_q[g] <= RST_V[g];
          flt_q[g] <= RST_V[g];
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          flt_q[g] <= flt_d[g];
        end
      end
    end
  endgenerate

  // edge detection on the filtered levels
  assign cs_low = ~flt_q[`SGE_PIN_CS];
  assign we_rise = flt_d[`SGE_PIN_WE] & ~flt_q[`SGE_PIN_WE] & cs_low; // R5 R20
  assign cs_rise = flt_d[`SGE_PIN_CS] & ~flt_q[`SGE_PIN_CS]; // R6

  // -----------------------------------------------
  // serial shifter: first bit in ends up at the top
  // -----------------------------------------------
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      shift_q <= '0;
      latch_q <= 1'b0;
      osc_rise_q <= 1'b0;
    end else begin
      if (we_rise) begin
        shift_q <= {shift_q[`SGE_WORD_W-2:0], flt_q[`SGE_PIN_DIN]}; // R1 R19
      end
      latch_q <= cs_rise;
      osc_rise_q <= flt_d[`SGE_PIN_OSC] & ~flt_q[`SGE_PIN_OSC];
    end
  end

  // older bits fall off the top, so only the last seven survive
  assign cfg.word = shift_q; // R6
  assign cfg.latch = latch_q;
  assign cfg.osc_rise = osc_rise_q;
  assign cfg.osc_level = flt_q[`SGE_PIN_OSC];
  assign cfg.ratio_sel = flt_q[`SGE_PIN_RSEL_MSB:`SGE_PIN_RSEL_LSB];
endmodule

// ### verilog/sge_top.sv
// serial gain and equalizer configuration block: register bank and sampling clock divider
//
// Overview of operation
// R1: host shifts a seven-bit configuration word in serially, one bit per strobe.
// R2: word bits one and zero select the target control register.
// R3: word bits two to five carry the setting field.
// R4: word bit six is the option bit governing power-down entry and exit.
// R5: with chip-select low, data is sampled on each write strobe rising edge.
// R6: chip-select rising edge applies the last seven sampled bits.
// R7: selects 00, 01, 10 with option one update only the addressed register.
// R8: select 11 with option zero clears power register, entering standby.
// R9: select 11 with option one sets power register, returning to active.
// R10: after power-up the block is active without any write.
// R11: while powered down both analog outputs are high impedance.
// R12: four control registers: fine gain, coarse gain, equalizer step, power bit.
// R13: select 00 takes equalizer step from low two field bits.
// R14: select 01 takes all four field bits as sixteen fine gain steps.
// R15: select 10 takes coarse gain from low two field bits.
// R16: ratio select picks oscillator division giving a 153.6 kHz sampling clock.
// R17: lowest ratio with a 2.56 MHz oscillator gives 160 kHz.
// R18: sampling clock leaves on an open-drain output.
// R19: option bit is shifted first and select bit zero last.
// R20: strobes with chip-select high and option-zero selects 00-10 change nothing.
`timescale 1ns/100ps
`include "sge_defs.svh"
module sge_top
  import sge_pkg::*;
#(
  parameter int P_HALF_HI = `SGE_HALF_HI,
  parameter int P_HALF_MID = `SGE_HALF_MID,
  parameter int P_HALF_LO = `SGE_HALF_LO
)
(
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // host serial port
  input wire logic i_cs_b,
  input wire logic i_we_b,
  input wire logic i_din,
  // oscillator and ratio strap
  input wire logic i_osc_input,
  input wire logic [1:0] i_clock_ratio_select,
  output logic o_osc_output,
  // sampling clock, open drain
  output logic o_sample_clock_out_o,
  output logic o_sample_clock_out_oe_b,
  // control register contents
  output logic [3:0] o_fine_gain_stage_step,
  output logic [1:0] o_coarse_gain_stage_step,
  output logic [1:0] o_eq_step,
  output logic o_active,
  // analog output enables
  output logic o_gain_analog_out_hiz,
  output logic o_equalizer_analog_out_hiz
);

  // -----------------------------------------------
  // parameter checks
  // -----------------------------------------------
  // the divider counter is six bits wide
  generate
    if (P_HALF_HI < 1 || P_HALF_HI > 63 || P_HALF_MID < 1 || P_HALF_MID > 63 ||
        P_HALF_LO < 1 || P_HALF_LO > 63) begin : g_bad_half
      $error("sge_top: divider half period out of range 1..63");
    end
  endgenerate

  // -----------------------------------------------
  // front end
  // -----------------------------------------------
  sge_cfg_if cfg ();

  sge_pin_rx u_rx (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_cs_b(i_cs_b),
    .i_we_b(i_we_b),
    .i_din(i_din),
    .i_osc_input(i_osc_input),
    .i_clock_ratio_select(i_clock_ratio_select),
    .cfg(cfg.rx)
  );

  // -----------------------------------------------
  // word decode
  // -----------------------------------------------
  logic [1:0] sel;
  logic [3:0] field;
  logic opt;
  wire wr_eq;
  wire wr_fine;
  wire wr_coarse;
  wire wr_power;

  // split the latched word into select, setting and option
  assign sel = cfg.word[`SGE_SEL_MSB:`SGE_SEL_LSB]; // R2
  assign field = cfg.word[`SGE_FIELD_MSB:`SGE_FIELD_LSB]; // R3
  assign opt = cfg.word[`SGE_OPT_BIT]; // R4

  // option zero on selects 00 to 10 writes nothing here
  assign wr_eq = cfg.latch & opt & (sel == SGE_SEL_EQ); // R7 R20
  assign wr_fine = cfg.latch & opt & (sel == SGE_SEL_FINE); // R7 R20
  assign wr_coarse = cfg.latch & opt & (sel == SGE_SEL_COARSE); // R7 R20
  assign wr_power = cfg.latch & (sel == SGE_SEL_POWER); // R8 R9

  // -----------------------------------------------
  // control registers
  // -----------------------------------------------
  logic [3:0] fine_q;
  logic [3:0] fine_d;
  logic [1:0] coarse_q;
  logic [1:0] coarse_d;
  logic [1:0] eq_q;
  logic [1:0] eq_d;
  logic active_q;
  logic active_d;
  logic hiz_q;

  // equalizer and coarse gain ignore the upper two field bits
  assign eq_d = wr_eq ? field[1:0] : eq_q; // R13
  assign fine_d = wr_fine ? field : fine_q; // R14
  assign coarse_d = wr_coarse ? field[1:0] : coarse_q; // R15
  // the option bit itself is the new power bit
  assign active_d = wr_power ? opt : active_q; // R8 R9

  // reset stands for power-up: active, gains at step zero
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      fine_q <= `SGE_FINE_RST;
      coarse_q <= `SGE_COARSE_RST;
      eq_q <= `SGE_EQ_RST;
      active_q <= `SGE_ACTIVE_RST; // R10
      hiz_q <= ~`SGE_ACTIVE_RST;
    end else begin
      fine_q <= fine_d; // R12
      coarse_q <= coarse_d;
      eq_q <= eq_d;
      active_q <= active_d;
      hiz_q <= ~active_d; // R11
    end
  end

  assign o_fine_gain_stage_step = fine_q;
  assign o_coarse_gain_stage_step = coarse_q;
  assign o_eq_step = eq_q;
  assign o_active = active_q;
  // both analog outputs float together with the power bit
  assign o_gain_analog_out_hiz = hiz_q;
  assign o_equalizer_analog_out_hiz = hiz_q;

  // -----------------------------------------------
  // sampling clock divider
  // -----------------------------------------------
  logic [5:0] half_sel;
  logic [5:0] div_q;
  logic [5:0] div_d;
  logic ck_q;
  logic ck_d;
  logic osc_out_q;
  logic od_data_q;
  wire div_wrap;

  // a 2.56 MHz part on the lowest ratio simply lands at 160 kHz
  assign half_sel = (cfg.ratio_sel == SGE_RATIO_VSS) ? 6'(P_HALF_LO) : // R16 R17
                    (cfg.ratio_sel == SGE_RATIO_DGND) ? 6'(P_HALF_MID) :
                    6'(P_HALF_HI);
  // >= so a strap change mid-count cannot leave the counter stranded
  assign div_wrap = (div_q >= (half_sel - 6'h01));
  assign div_d = !cfg.osc_rise ? div_q : (div_wrap ? 6'h00 : div_q + 6'h01);
  assign ck_d = (cfg.osc_rise && div_wrap) ? ~ck_q : ck_q; // R16

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      div_q <= 6'h00;
      ck_q <= 1'b1;
      osc_out_q <= 1'b1;
      od_data_q <= 1'b0;
    end else begin
      div_q <= div_d;
      ck_q <= ck_d;
      osc_out_q <= ~cfg.osc_level;
      od_data_q <= 1'b0; // R18
    end
  end

  // open drain: only ever pulls low, high level is a release
  // the data side sits in a flop like every other output and never leaves zero
  assign o_sample_clock_out_o = od_data_q; // R18
  assign o_sample_clock_out_oe_b = ck_q; // R18
  // inverting stage of the oscillator
  assign o_osc_output = osc_out_q;

  // -----------------------------------------------
  // assertions
  // -----------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_b);

  sequence s_latch_opt1(logic [1:0] s);
    cfg.latch && opt && (sel == s);
  endsequence

  sequence s_latch_power(logic o);
    cfg.latch && (sel == SGE_SEL_POWER) && (opt == o);
  endsequence

  property p_eq_update;
    s_latch_opt1(SGE_SEL_EQ) |=> (o_eq_step == $past(field[1:0])) &&
      $stable(o_fine_gain_stage_step) && $stable(o_coarse_gain_stage_step) && $stable(o_active);
  endproperty
  a_eq_update: assert property (p_eq_update) else $error("equalizer step not taken"); // R13

  property p_fine_update;
    s_latch_opt1(SGE_SEL_FINE) |=> (o_fine_gain_stage_step == $past(cfg.word[5:2])) &&
      $stable(o_eq_step) && $stable(o_coarse_gain_stage_step);
  endproperty
  a_fine_update: assert property (p_fine_update) else $error("fine gain step not taken"); // R14

  property p_coarse_update;
    s_latch_opt1(SGE_SEL_COARSE) |=> (o_coarse_gain_stage_step == $past(cfg.word[3:2])) &&
      $stable(o_eq_step) && $stable(o_fine_gain_stage_step);
  endproperty
  a_coarse_update: assert property (p_coarse_update) else $error("coarse gain step not taken"); // R15

  property p_power_down;
    s_latch_power(1'b0) |=> !o_active ##1 o_gain_analog_out_hiz;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power down not entered"); // R8

  property p_power_up;
    s_latch_power(1'b1) |=> o_active && !o_equalizer_analog_out_hiz;
  endproperty
  a_power_up: assert property (p_power_up) else $error("active mode not restored"); // R9

  property p_opt0_ignored;
    cfg.latch && !opt && (sel != SGE_SEL_POWER) |=> $stable(o_eq_step) &&
      $stable(o_fine_gain_stage_step) && $stable(o_coarse_gain_stage_step) && $stable(o_active);
  endproperty
  a_opt0_ignored: assert property (p_opt0_ignored) else $error("option zero word changed state"); // R20

  property p_idle_hold;
    (!cfg.latch) [*3] |=> $stable(o_eq_step) && $stable(o_fine_gain_stage_step) &&
      $stable(o_coarse_gain_stage_step) && $stable(o_active);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("register changed without a latch"); // R6

  property p_hiz_tracks;
    o_gain_analog_out_hiz == !o_active && o_equalizer_analog_out_hiz == !o_active;
  endproperty
  a_hiz_tracks: assert property (p_hiz_tracks) else $error("analog outputs not floating with power bit"); // R11

  property p_reset_active;
    $rose(i_rst_b) |-> o_active && !o_gain_analog_out_hiz && (o_fine_gain_stage_step == 4'h0);
  endproperty
  a_reset_active: assert property (p_reset_active) else $error("not active after reset"); // R10

  property p_ck_toggle;
    cfg.osc_rise && (div_q >= half_sel - 6'h01) |=> o_sample_clock_out_oe_b != $past(o_sample_clock_out_oe_b);
  endproperty
  a_ck_toggle: assert property (p_ck_toggle) else $error("sampling clock missed its toggle"); // R16

  property p_ck_steady;
    !(cfg.osc_rise && div_wrap) |=> $stable(o_sample_clock_out_oe_b);
  endproperty
  a_ck_steady: assert property (p_ck_steady) else $error("sampling clock toggled early"); // R17

  property p_od_low;
    !o_sample_clock_out_o;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open-drain output drove high"); // R18

  // -----------------------------------------------
  // register and clock invariants
  // -----------------------------------------------
  // the latch strobe lasts one cycle, so a word is applied exactly once
  property p_latch_pulse;
    cfg.latch |=> !cfg.latch;
  endproperty
  a_latch_pulse: assert property (p_latch_pulse) else $error("latch strobe longer than one cycle"); // R6

  // a register moves only on the cycle after a latch that addresses it
  property p_eq_only_own;
    $changed(o_eq_step) |-> $past(wr_eq);
  endproperty
  a_eq_only_own: assert property (p_eq_only_own) else $error("equalizer step moved unaddressed"); // R7

  property p_fine_only_own;
    $changed(o_fine_gain_stage_step) |-> $past(wr_fine);
  endproperty
  a_fine_only_own: assert property (p_fine_only_own) else $error("fine gain moved unaddressed"); // R7

  property p_coarse_only_own;
    $changed(o_coarse_gain_stage_step) |-> $past(wr_coarse);
  endproperty
  a_coarse_only_own: assert property (p_coarse_only_own) else $error("coarse gain moved unaddressed"); // R7

  property p_power_only_own;
    $changed(o_active) |-> $past(wr_power);
  endproperty
  a_power_only_own: assert property (p_power_only_own) else $error("power bit moved unaddressed"); // R9

  // one latch can address at most one register
  property p_one_target;
    $onehot0({wr_eq, wr_fine, wr_coarse, wr_power});
  endproperty
  a_one_target: assert property (p_one_target) else $error("latch addressed two registers"); // R2

  // standby is left only through a select-three word with option one
  property p_standby_holds;
    !o_active && !(wr_power && opt) |=> !o_active;
  endproperty
  a_standby_holds: assert property (p_standby_holds) else $error("left standby without an active word"); // R8

  // active mode is left only through a select-three word with option zero
  property p_active_holds;
    o_active && !(wr_power && !opt) |=> o_active;
  endproperty
  a_active_holds: assert property (p_active_holds) else $error("left active without a standby word"); // R10

  // both analog outputs float on the very cycle the power bit falls
  sequence s_enter_standby;
    o_active ##1 !o_active;
  endsequence

  property p_standby_float;
    s_enter_standby |-> o_gain_analog_out_hiz && o_equalizer_analog_out_hiz;
  endproperty
  a_standby_float: assert property (p_standby_float) else $error("analog outputs driven in standby"); // R11

  // the sampling clock only moves one cycle after a counted oscillator rise
  property p_ck_from_osc;
    $changed(o_sample_clock_out_oe_b) |-> $past(cfg.osc_rise);
  endproperty
  a_ck_from_osc: assert property (p_ck_from_osc) else $error("sampling clock moved off its rise"); // R16

  // the oscillator stage inverts the filtered level one cycle late
  property p_osc_out_follow;
    o_osc_output == !$past(cfg.osc_level);
  endproperty
  a_osc_out_follow: assert property (p_osc_out_follow) else $error("oscillator output not inverted"); // R16

endmodule

// ### testbench/sge_host_model.sv
// host model: drives chip-select, write strobe and serial data into the block
`timescale 1ns/100ps
module sge_host_model (
  // system clock, used only to pace the pins
  input wire logic i_sys_clk,
  // serial port pins toward the block
  output logic o_cs_b,
  output logic o_we_b,
  output logic o_din
);
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    o_cs_b = 1'b1;
    o_we_b = 1'b1;
    o_din = 1'b0;
  end

  // ----------------------------------------
  // pin timing helpers
  // ----------------------------------------
  // every level stands at least 4 clocks so the 3-flop filters always agree
  task automatic wait_clk(input int k);
    repeat (k) @(posedge i_sys_clk);
  endtask

  // shift n bits, most significant first, then close with chip-select
  task automatic send_bits(input logic [15:0] bits, input int n);
    wait_clk(1);
    o_cs_b <= 1'b0;
    wait_clk(8);
    for (int i = n - 1; i >= 0; i--) begin
      o_din <= bits[i];
      wait_clk(4);
      o_we_b <= 1'b0;
      wait_clk(8);
      o_we_b <= 1'b1;
      wait_clk(8);
    end
    o_cs_b <= 1'b1;
    // the line is not qualified any more, so it must not keep the last bit
    o_din <= ~o_din;
    wait_clk(8);
  endtask

  // strobes while deselected, which the block has to ignore
  task automatic stray(input int n);
    repeat (n) begin
      wait_clk(1);
      o_din <= 1'b0;
      wait_clk(4);
      o_we_b <= 1'b0;
      wait_clk(8);
      o_we_b <= 1'b1;
      wait_clk(8);
    end
  endtask
endmodule

// ### testbench/sge_tb_top.sv
// self-checking testbench of the serial gain and equalizer configuration block
`timescale 1ns/100ps
module sge_tb_top;
  import sge_pkg::*;
  typedef struct {
    logic [6:0] word;
    logic [3:0] fine;
    logic [1:0] coarse;
    logic [1:0] eq;
    logic active;
  } sge_row_s;
  // ----------------------------------------
  // clocks, pins and counters
  // ----------------------------------------
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic osc = 1'b0;
  logic [1:0] ratio = 2'h0;
  logic cs_b;
  logic we_b;
  logic din;
  logic ck_o;
  logic ck_oe_b;
  logic active;
  logic hiz_a;
  logic hiz_e;
  logic [3:0] fine;
  logic [1:0] coarse;
  logic [1:0] eq;
  int n_fail = 0;
  int n_checks = 0;
  int n_osc = 0;
  logic osc_out;
  int n_xo = 0;
  always #10 i_sys_clk = ~i_sys_clk;
  // oscillator pin, exactly eight system clock periods per cycle, switching on system clock falling edges
  always #80 osc = ~osc;
  always @(posedge osc) n_osc <= n_osc + 1;
  // every oscillator rise should come back as one fall of the inverting stage
  always @(negedge osc_out) n_xo <= n_xo + 1;

  // ----------------------------------------
  // host and design
  // ----------------------------------------
  sge_host_model host (.i_sys_clk(i_sys_clk), .o_cs_b(cs_b), .o_we_b(we_b), .o_din(din));
  // short divider counts keep the run brief
  sge_top #(.P_HALF_HI(2), .P_HALF_MID(3), .P_HALF_LO(4)) dut (
    .i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_we_b(we_b), .i_din(din),
    .i_osc_input(osc), .i_clock_ratio_select(ratio), .o_osc_output(osc_out),
    .o_sample_clock_out_o(ck_o), .o_sample_clock_out_oe_b(ck_oe_b),
    .o_fine_gain_stage_step(fine), .o_coarse_gain_stage_step(coarse), .o_eq_step(eq),
    .o_active(active), .o_gain_analog_out_hiz(hiz_a), .o_equalizer_analog_out_hiz(hiz_e)
  );

  // ----------------------------------------
  // checking tasks
  // ----------------------------------------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_state(input logic [3:0] f, input logic [1:0] c, input logic [1:0] e, input logic a);
    chk({4'h0, fine}, {4'h0, f}, "fine gain");
    chk({6'h0, coarse}, {6'h0, c}, "coarse gain");
    chk({6'h0, eq}, {6'h0, e}, "equalizer step");
    chk({7'h0, active}, {7'h0, a}, "power bit");
    chk({6'h0, hiz_a, hiz_e}, {6'h0, ~a, ~a}, "analog float");
    chk({7'h0, ck_o}, 8'h00, "open drain data");
  endtask

  // bounded wait for the next sampling clock edge
  task automatic wait_toggle();
    logic last;
    int k;
    last = ck_oe_b;
    k = 0;
    while (ck_oe_b === last && k < 400) begin
      @(posedge i_sys_clk);
      #1;
      k++;
    end
    if (k >= 400) begin
      n_fail++;
      $display("wrong value at %0t: sampling clock stuck", $time);
      print_verdict();
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    sge_row_s rows[12];
    logic [7:0] halves[4];
    int a;
    int b;
    rows = '{'{7'h69, 4'ha, 2'h0, 2'h0, 1'b1}, '{7'h7a, 4'ha, 2'h2, 2'h0, 1'b1},
             '{7'h6c, 4'ha, 2'h2, 2'h3, 1'b1}, '{7'h7d, 4'hf, 2'h2, 2'h3, 1'b1},
             '{7'h4e, 4'hf, 2'h3, 2'h3, 1'b1}, '{7'h40, 4'hf, 2'h3, 2'h0, 1'b1},
             '{7'h15, 4'hf, 2'h3, 2'h0, 1'b1}, '{7'h03, 4'hf, 2'h3, 2'h0, 1'b0},
             '{7'h41, 4'h0, 2'h3, 2'h0, 1'b0}, '{7'h43, 4'h0, 2'h3, 2'h0, 1'b1},
             '{7'h47, 4'h0, 2'h3, 2'h0, 1'b1}, '{7'h3a, 4'h0, 2'h3, 2'h0, 1'b1}};
    halves = '{8'h04, 8'h03, 8'h02, 8'h02};
    // three reset edges load every pin filter with its idle level
    repeat (3) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk_state(4'h0, 2'h0, 2'h0, 1'b1);
    // plain words: every select with option one, selects 01 to 11 with option zero
    foreach (rows[i]) begin
      host.send_bits({9'h000, rows[i].word}, 7);
      #1;
      chk_state(rows[i].fine, rows[i].coarse, rows[i].eq, rows[i].active);
    end
    // two leading bits beyond seven fall out of the word
    host.send_bits(16'h01d9, 9);
    #1;
    chk_state(4'h6, 2'h3, 2'h0, 1'b1);
    // deselected strobes must not shift; two new bits complete the old word
    host.stray(3);
    host.send_bits(16'h0002, 2);
    #1;
    chk_state(4'h6, 2'h1, 2'h0, 1'b1);
    // standby, then a second reset returns to the active defaults
    host.send_bits(16'h0003, 7);
    #1;
    chk_state(4'h6, 2'h1, 2'h0, 1'b0);
    @(posedge i_sys_clk);
    i_rst_b <= 1'b0;
    repeat (4) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk_state(4'h0, 2'h0, 2'h0, 1'b1);
    // divider: oscillator rises per half period for each strap value
    for (int s = 0; s < 4; s++) begin
      @(posedge i_sys_clk);
      ratio <= 2'(s);
      wait_toggle();
      wait_toggle();
      a = n_osc;
      b = n_xo;
      wait_toggle();
      chk(8'(n_osc - a), halves[s], "divider half period");
      chk(8'(n_xo - b), halves[s], "oscillator output edges");
    end
    print_verdict();
  end
endmodule
